// *** src/qms_pkg.sv ***
/*
 Shared constants, types and helper functions for the quad-lane serial
 memory slave port and its write buffer.
 Assumes a single core clock domain; all serial pins are sampled by it.
*/
// Summary of operation
// - slave in clock mode 0 only; serial clock up to 30/25 MHz; the port samples at most CORE_CLK_HZ / SCLK_MIN_CORE_CYC = 3.125 MHz.
// - after reset single lane: receive on lane zero, drive read data on lane one.
// - lane width changes only by a port write or the system reset command: 00 single, 01 dual, 10 quad.
// - dual: lane one is msb; quad: lanes three, two, one, zero in order.
// - in dual and quad all lanes are inputs when select falls.
// - in dual and quad, lanes turn to outputs only when the first read byte starts, never in dummy.
// - in dual and quad nobody drives the lanes during the dummy byte; resistors hold the level.
// - select rising returns every lane to input.
// - a 4 megabyte memory-mapped space is reached by reads and writes.
// - memory read, memory write and command write; msb first.
// - select low frames a transaction; any number of bytes at consecutive addresses.
// - read: two zero bits, 22-bit address, dummy byte, then one byte per byte.
// - write: bits one then zero, 22-bit address, then data with no dummy.
// - write data counts as committed when select rises.
// - command: 01 plus 6-bit code, parameter byte, zero byte.
// - commands run only in single mode, except the system reset command.
package qms_pkg;

    localparam int ADDR_W = 22;
    localparam int CORE_CLK_HZ = 25_000_000;
    localparam int SCLK_MAX_WIDE_HZ = 30_000_000;
    localparam int SCLK_MAX_QUAD_HZ = 25_000_000;
    // fewest core clocks per serial period that the edge finder needs
    localparam int SCLK_MIN_CORE_CYC = 8;
    localparam int SCLK_MAX_SAMPLED_HZ = CORE_CLK_HZ / SCLK_MIN_CORE_CYC;

    localparam logic [1:0] WIDTH_SINGLE = 2'h0;
    localparam logic [1:0] WIDTH_DUAL = 2'h1;
    localparam logic [1:0] WIDTH_QUAD = 2'h2;
    localparam logic [1:0] WIDTH_RSVD = 2'h3;
    localparam logic [1:0] WIDTH_RST = 2'h0;
    localparam logic [ADDR_W-1:0] WIDTH_REG_ADDR = 22'h3FFFFC;

    localparam logic [1:0] HDR_READ = 2'h0;
    localparam logic [1:0] HDR_CMD = 2'h1;
    localparam logic [1:0] HDR_WRITE = 2'h2;
    localparam logic [1:0] HDR_BAD = 2'h3;
    localparam logic [1:0] HDR_LAST = 2'h2;
    localparam logic [5:0] CMD_SYS_RESET = 6'h28;

    // {lane3, lane2, lane1, lane0, cs_n, sclk}
    localparam logic [5:0] SYNC_RST = 6'h02;
    localparam int WR_FIFO_DEPTH = 8;
    localparam int WR_FIFO_W = ADDR_W + 8;

    typedef enum logic [2:0] {PH_IDLE, PH_HDR, PH_DUMMY, PH_RDATA, PH_WDATA, PH_IGNORE} qms_phase_t;

    function automatic logic [3:0] lane_step(input logic [1:0] w);
        unique case (w)
            WIDTH_DUAL: lane_step = 4'h2;
            WIDTH_QUAD: lane_step = 4'h4;
            default: lane_step = 4'h1;
        endcase
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] l, input logic [1:0] w);
        unique case (w)
            WIDTH_DUAL: shift_in = {s[5:0], l[1:0]};
            WIDTH_QUAD: shift_in = {s[3:0], l};
            default: shift_in = {s[6:0], l[0]};
        endcase
    endfunction

    function automatic logic [7:0] shift_out(input logic [7:0] s, input logic [1:0] w);
        unique case (w)
            WIDTH_DUAL: shift_out = {s[5:0], 2'h0};
            WIDTH_QUAD: shift_out = {s[3:0], 4'h0};
            default: shift_out = {s[6:0], 1'h0};
        endcase
    endfunction

    // {lane3, lane2, lane1, lane0} drive values
    function automatic logic [3:0] lane_place(input logic [7:0] s, input logic [1:0] w);
        unique case (w)
            WIDTH_DUAL: lane_place = {2'h0, s[7:6]};
            WIDTH_QUAD: lane_place = s[7:4];
            default: lane_place = {2'h0, s[7], 1'h0};
        endcase
    endfunction

    function automatic logic [3:0] lane_oe(input logic [1:0] w);
        unique case (w)
            WIDTH_DUAL: lane_oe = 4'h3;
            WIDTH_QUAD: lane_oe = 4'hF;
            default: lane_oe = 4'h2;
        endcase
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        reg_hit = (a == WIDTH_REG_ADDR);
    endfunction

endpackage

// *** src/qms_fifo.sv ***
/*
 Write buffer: flip-flop FIFO with valid/ready on both sides.
 Assumes one clock; ce freezes all state while low.
*/
`timescale 1ns/1ns
module qms_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("fifo depth must be a power of two, at least 2");
        end
    endgenerate

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign out_data = mem_r[rd_ptr_r[AW-1:0]];
    assign push = ce & in_valid & in_ready;
    assign pop = ce & out_valid & out_ready;

    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule

// *** src/qms_port.sv ***
/*
 Quad-lane serial memory slave port: frames read, write and command
 transactions from a mode-0 master, keeps the lane width setting, issues
 memory reads and buffers memory writes.
 Assumes every pin is asynchronous to core_clk and that the serial clock
 period is at least SCLK_MIN_CORE_CYC core clocks.
*/
`timescale 1ns/1ns
module qms_port
    import qms_pkg::*;
#(
    parameter int FIFO_DEPTH = WR_FIFO_DEPTH
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic lane_zero_pin,
    output logic lane_zero_drv,
    output logic lane_zero_oe,
    input wire logic lane_one_pin,
    output logic lane_one_drv,
    output logic lane_one_oe,
    input wire logic quad_lane_two_pin,
    output logic quad_lane_two_drv,
    output logic quad_lane_two_oe,
    input wire logic quad_lane_three_pin,
    output logic quad_lane_three_drv,
    output logic quad_lane_three_oe,
    output logic mem_rd_req,
    output logic [ADDR_W-1:0] mem_rd_addr,
    input wire logic mem_rd_valid,
    input wire logic [7:0] mem_rd_data,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [ADDR_W-1:0] mem_wr_addr,
    output logic [7:0] mem_wr_data,
    output logic wr_buf_ready,
    output logic wr_overflow,
    output logic wr_commit,
    output logic cmd_valid,
    output logic [5:0] cmd_code,
    output logic [7:0] cmd_param,
    output logic [1:0] lane_width
);
    logic [5:0] meta_r;
    logic [5:0] sync_r;
    logic sclk_d_r;
    logic csn_d_r;
    qms_phase_t phase_r;
    logic [2:0] bit_cnt_r;
    logic [1:0] hdr_cnt_r;
    logic [7:0] rx_r;
    logic [15:0] hdr_r;
    logic [ADDR_W-1:0] addr_r;
    logic [1:0] width_r;
    logic [1:0] pend_r;
    logic pend_vld_r;
    logic wrote_r;
    logic [7:0] rd_byte_r;
    logic [7:0] tx_r;
    logic [3:0] lane_out_r;
    logic [3:0] oe_r;

    logic cs_act;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] rx_nxt;
    logic [3:0] cnt_sum;
    logic byte_done;
    logic [23:0] hdr_full;
    logic hdr_end;
    logic rd_start;
    logic cmd_hit;
    logic cmd_ok;
    logic wr_byte;
    logic wr_push;
    logic wr_reg;
    logic tx_load;
    logic [7:0] tx_shift;
    logic [ADDR_W-1:0] rd_next_addr;
    logic fifo_in_ready;

    // two-stage synchronisers for every pin
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= SYNC_RST;
            sync_r <= SYNC_RST;
            sclk_d_r <= SYNC_RST[0];
            csn_d_r <= SYNC_RST[1];
        end
        else if (ce)
        begin
            meta_r <= {quad_lane_three_pin, quad_lane_two_pin, lane_one_pin, lane_zero_pin, cs_n, sclk};
            sync_r <= meta_r;
            sclk_d_r <= sync_r[0];
            csn_d_r <= sync_r[1];
        end
    end

    assign cs_act = ~sync_r[1];
    assign cs_fall = ce & ~sync_r[1] & csn_d_r;
    assign cs_rise = ce & sync_r[1] & ~csn_d_r;
    // mode 0: sample on rising, shift on falling
    assign sclk_rise = ce & cs_act & sync_r[0] & ~sclk_d_r;
    assign sclk_fall = ce & cs_act & ~sync_r[0] & sclk_d_r;

    assign rx_nxt = shift_in(rx_r, sync_r[5:2], width_r);
    assign cnt_sum = {1'b0, bit_cnt_r} + lane_step(width_r);
    assign byte_done = sclk_rise & cnt_sum[3] & (phase_r != PH_IDLE);
    assign hdr_full = {hdr_r, rx_nxt};
    assign hdr_end = byte_done && phase_r == PH_HDR && hdr_cnt_r == HDR_LAST;
    assign rd_start = hdr_end && hdr_full[23:22] == HDR_READ;
    assign cmd_hit = hdr_end && hdr_full[23:22] == HDR_CMD;
    assign cmd_ok = cmd_hit && (width_r == WIDTH_SINGLE || hdr_full[21:16] == CMD_SYS_RESET);
    assign wr_byte = byte_done && phase_r == PH_WDATA;
    assign wr_push = wr_byte && !reg_hit(addr_r);
    assign wr_reg = wr_byte && reg_hit(addr_r);
    assign tx_load = sclk_fall && phase_r == PH_RDATA && bit_cnt_r == 3'h0;
    assign tx_shift = shift_out(tx_r, width_r);
    assign rd_next_addr = rd_start ? hdr_full[ADDR_W-1:0] : addr_r + 22'h1;

    // transaction framing
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_r <= PH_IDLE;
            bit_cnt_r <= 3'h0;
            hdr_cnt_r <= 2'h0;
            rx_r <= 8'h00;
            hdr_r <= 16'h0000;
            addr_r <= 22'h000000;
        end
        else if (ce)
        begin
            if (!cs_act)
                phase_r <= PH_IDLE;
            else if (cs_fall)
            begin
                phase_r <= PH_HDR;
                bit_cnt_r <= 3'h0;
                hdr_cnt_r <= 2'h0;
            end
            else if (tx_load)
                addr_r <= addr_r + 22'h1;
            else if (sclk_rise && phase_r != PH_IDLE)
            begin
                rx_r <= rx_nxt;
                bit_cnt_r <= cnt_sum[2:0];
                if (cnt_sum[3])
                begin
                    unique case (phase_r)
                        PH_HDR:
                        begin
                            hdr_r <= hdr_full[15:0];
                            hdr_cnt_r <= hdr_cnt_r + 2'h1;
                            if (hdr_cnt_r == 2'h0 && rx_nxt[7:6] == HDR_BAD)
                                phase_r <= PH_IGNORE;
                            else if (hdr_cnt_r == HDR_LAST)
                            begin
                                addr_r <= hdr_full[ADDR_W-1:0];
                                if (hdr_full[23:22] == HDR_READ)
                                    phase_r <= PH_DUMMY;
                                else if (hdr_full[23:22] == HDR_WRITE)
                                    phase_r <= PH_WDATA;
                                else
                                    phase_r <= PH_IGNORE;
                            end
                        end
                        PH_DUMMY:
                            phase_r <= PH_RDATA;
                        PH_WDATA:
                            addr_r <= addr_r + 22'h1;
                        default:
                            phase_r <= phase_r;
                    endcase
                end
            end
        end
    end

    // lane width setting, applied when the select line rises
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            width_r <= WIDTH_RST;
            pend_r <= WIDTH_RST;
            pend_vld_r <= 1'b0;
        end
        else if (ce)
        begin
            if (cs_rise)
            begin
                if (pend_vld_r)
                    width_r <= pend_r;
                pend_vld_r <= 1'b0;
            end
            else if (wr_reg && rx_nxt[1:0] != WIDTH_RSVD)
            begin
                pend_r <= rx_nxt[1:0];
                pend_vld_r <= 1'b1;
            end
            else if (cmd_ok && hdr_full[21:16] == CMD_SYS_RESET)
            begin
                pend_r <= WIDTH_SINGLE;
                pend_vld_r <= 1'b1;
            end
        end
    end

    // commands, write completion and buffer overrun status
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_valid <= 1'b0;
            cmd_code <= 6'h00;
            cmd_param <= 8'h00;
            wrote_r <= 1'b0;
            wr_commit <= 1'b0;
            wr_overflow <= 1'b0;
        end
        else if (ce)
        begin
            cmd_valid <= cmd_ok;
            if (cmd_ok)
            begin
                cmd_code <= hdr_full[21:16];
                cmd_param <= hdr_full[15:8];
            end
            wr_commit <= cs_rise & wrote_r;
            if (cs_fall)
                wrote_r <= 1'b0;
            else if (wr_byte)
                wrote_r <= 1'b1;
            // overrun wins over the clear
            if (wr_push && !fifo_in_ready)
                wr_overflow <= 1'b1;
            else if (cs_fall)
                wr_overflow <= 1'b0;
        end
    end

    // read requests, one byte ahead of the shifter
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mem_rd_req <= 1'b0;
            mem_rd_addr <= 22'h000000;
            rd_byte_r <= 8'h00;
        end
        else if (ce)
        begin
            mem_rd_req <= 1'b0;
            if (rd_start || tx_load)
            begin
                mem_rd_addr <= rd_next_addr;
                if (reg_hit(rd_next_addr))
                    rd_byte_r <= {6'h00, width_r};
                else
                    mem_rd_req <= 1'b1;
            end
            else if (mem_rd_valid)
                rd_byte_r <= mem_rd_data;
        end
    end

    // output shifter and lane direction
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_r <= 8'h00;
            lane_out_r <= 4'h0;
            oe_r <= 4'h0;
        end
        else if (ce)
        begin
            if (!cs_act)
            begin
                oe_r <= 4'h0;
                tx_r <= 8'h00;
                lane_out_r <= 4'h0;
            end
            else if (cs_fall)
            begin
                // multi-lane frames open with every lane an input
                oe_r <= (width_r == WIDTH_SINGLE) ? lane_oe(WIDTH_SINGLE) : 4'h0;
                tx_r <= 8'h00;
                lane_out_r <= 4'h0;
            end
            else if (tx_load)
            begin
                tx_r <= rd_byte_r;
                lane_out_r <= lane_place(rd_byte_r, width_r);
                oe_r <= lane_oe(width_r);
            end
            else if (sclk_fall && phase_r == PH_RDATA)
            begin
                tx_r <= tx_shift;
                lane_out_r <= lane_place(tx_shift, width_r);
            end
        end
    end

    assign {quad_lane_three_drv, quad_lane_two_drv, lane_one_drv, lane_zero_drv} = lane_out_r;
    assign {quad_lane_three_oe, quad_lane_two_oe, lane_one_oe, lane_zero_oe} = oe_r;
    assign lane_width = width_r;

    qms_fifo #(
        .W(WR_FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .in_valid(wr_push),
        .in_ready(fifo_in_ready),
        .in_data({addr_r, rx_nxt}),
        .out_valid(mem_wr_valid),
        .out_ready(mem_wr_ready),
        .out_data({mem_wr_addr, mem_wr_data})
    );
    assign wr_buf_ready = fifo_in_ready;

    property p_release_at_end;
        @(posedge core_clk) disable iff (rst)
        cs_rise |=> (oe_r == 4'h0) [*2];
    endproperty
    a_release_at_end: assert property (p_release_at_end) else $error("lanes still driven after select rose");

    property p_multi_start_input;
        @(posedge core_clk) disable iff (rst)
        cs_fall && width_r != WIDTH_SINGLE |=> oe_r == 4'h0;
    endproperty
    a_multi_start_input: assert property (p_multi_start_input) else $error("multi-lane frame did not start as input");

    property p_single_miso;
        @(posedge core_clk) disable iff (rst)
        cs_fall && width_r == WIDTH_SINGLE |=> oe_r == 4'h2;
    endproperty
    a_single_miso: assert property (p_single_miso) else $error("single mode must drive lane one only");

    property p_dummy_quiet;
        @(posedge core_clk) disable iff (rst)
        (phase_r == PH_DUMMY || phase_r == PH_HDR) && width_r != WIDTH_SINGLE |-> oe_r == 4'h0;
    endproperty
    a_dummy_quiet: assert property (p_dummy_quiet) else $error("lanes driven before first read byte");

    property p_quad_map;
        @(posedge core_clk) disable iff (rst)
        tx_load && width_r == WIDTH_QUAD |=> oe_r == 4'hF && lane_out_r == $past(rd_byte_r[7:4]);
    endproperty
    a_quad_map: assert property (p_quad_map) else $error("quad lane order wrong");

    property p_width_at_end;
        @(posedge core_clk) disable iff (rst)
        width_r != $past(width_r) |-> $past(cs_rise);
    endproperty
    a_width_at_end: assert property (p_width_at_end) else $error("width changed inside a frame");

    property p_addr_step;
        @(posedge core_clk) disable iff (rst)
        wr_byte |=> addr_r == $past(addr_r) + 22'h1;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address did not step after write byte");

    property p_cmd_single;
        @(posedge core_clk) disable iff (rst)
        cmd_valid |-> width_r == WIDTH_SINGLE || cmd_code == CMD_SYS_RESET;
    endproperty
    a_cmd_single: assert property (p_cmd_single) else $error("command accepted outside single mode");

    property p_bad_ignored;
        @(posedge core_clk) disable iff (rst)
        phase_r == PH_IGNORE |=> !mem_rd_req && !cmd_valid && $stable(addr_r) && oe_r != 4'hF;
    endproperty
    a_bad_ignored: assert property (p_bad_ignored) else $error("ignored frame produced traffic");

    property p_commit;
        @(posedge core_clk) disable iff (rst)
        cs_rise && wrote_r |=> wr_commit ##1 !wr_commit;
    endproperty
    a_commit: assert property (p_commit) else $error("write not committed at select rise");
endmodule

// *** testbench/qms_host.sv ***
/*
 Serial master model for the slave port: mode-0 clock, select framing,
 single/dual/quad lanes, pull-ups on every lane.
 Assumes the core clock paces the model; tasks are called from the bench.
*/
`timescale 1ns/1ns
module qms_host
(
    input wire logic core_clk,
    input wire logic [3:0] lane_oe,
    input wire logic [3:0] lane_drv,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] lane_pin,
    output logic rx_stb,
    output logic [7:0] rx_byte,
    output logic probe,
    output logic rx_phase
);
    logic [3:0] host_en = 4'h0;
    logic [3:0] host_val = 4'h0;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        rx_stb = 1'b0;
        rx_byte = 8'h00;
        probe = 1'b0;
        rx_phase = 1'b0;
    end
    // undriven lanes float to the pull-up level
    assign lane_pin = (lane_oe & lane_drv) | (~lane_oe & host_en & host_val) | (~lane_oe & ~host_en);
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic start();
        cs_n <= 1'b0;
        tick(4);
    endtask
    task automatic stop();
        sclk <= 1'b0;
        tick(4);
        cs_n <= 1'b1;
        host_en <= 4'h0;
        rx_phase <= 1'b0;
        tick(8);
    endtask
    // one byte, msb first; a released byte leaves all lanes to the port
    task automatic xbyte(input logic [1:0] w, input logic [7:0] tx, input logic drive, input logic rd);
        logic [7:0] s;
        logic [7:0] r;
        int k;
        k = (w == 2'h2) ? 4 : (w == 2'h1) ? 2 : 1;
        s = tx;
        r = 8'h00;
        rx_phase <= rd;
        host_en <= !drive ? 4'h0 : (k == 4) ? 4'hF : (k == 2) ? 4'h3 : 4'h1;
        for (int i = 0; i < 8; i += k)
        begin
            sclk <= 1'b0;
            host_val <= (k == 4) ? s[7:4] : (k == 2) ? {2'h0, s[7:6]} : {3'h0, s[7]};
            tick(4);
            r = (k == 4) ? {r[3:0], lane_pin} : (k == 2) ? {r[5:0], lane_pin[1:0]} : {r[6:0], lane_pin[1]};
            s = s << k;
            sclk <= 1'b1;
            probe <= 1'b1;
            tick(1);
            probe <= 1'b0;
            tick(3);
        end
        if (rd)
        begin
            rx_byte <= r;
            rx_stb <= 1'b1;
            tick(1);
            rx_stb <= 1'b0;
        end
    endtask
endmodule

// *** testbench/qspi_memory_slave_port_test.sv ***
/*
 Self-checking bench for the serial memory slave port.
 Assumes the qms_host master model and a one-cycle memory behind the port.
*/
`timescale 1ns/1ns
module qspi_memory_slave_port_test
    import qms_pkg::*;
;
    localparam int DEPTH = 8;
    logic core_clk, rst, sclk, cs_n, rx_stb, probe, rx_phase, hold, ce;
    logic [3:0] pin, drv, oe;
    logic [7:0] rx_byte, mem_rd_data, mem_wr_data, cmd_param;
    logic [ADDR_W-1:0] mem_rd_addr, mem_wr_addr, base;
    logic mem_rd_req, mem_rd_valid, mem_wr_valid, mem_wr_ready, wr_buf_ready, wr_overflow, wr_commit, cmd_valid;
    logic [5:0] cmd_code;
    logic [1:0] lane_width, cur_w;
    logic [29:0] wq[$], cq[$], rq[$], mq[$];
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    qms_port #(.FIFO_DEPTH(DEPTH)) DUT (.core_clk(core_clk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n),
        .lane_zero_pin(pin[0]), .lane_zero_drv(drv[0]), .lane_zero_oe(oe[0]),
        .lane_one_pin(pin[1]), .lane_one_drv(drv[1]), .lane_one_oe(oe[1]),
        .quad_lane_two_pin(pin[2]), .quad_lane_two_drv(drv[2]), .quad_lane_two_oe(oe[2]),
        .quad_lane_three_pin(pin[3]), .quad_lane_three_drv(drv[3]), .quad_lane_three_oe(oe[3]),
        .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .wr_buf_ready(wr_buf_ready), .wr_overflow(wr_overflow), .wr_commit(wr_commit),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_param(cmd_param), .lane_width(lane_width));
    qms_host h (.core_clk(core_clk), .lane_oe(oe), .lane_drv(drv), .sclk(sclk), .cs_n(cs_n), .lane_pin(pin),
        .rx_stb(rx_stb), .rx_byte(rx_byte), .probe(probe), .rx_phase(rx_phase));
    task automatic cmp(input logic [29:0] got, input logic [29:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // memory answers one cycle after each request; outputs are matched to notes
    always @(posedge core_clk)
    begin
        mem_rd_valid <= mem_rd_req;
        mem_rd_data <= mem_rd_addr[7:0] ^ 8'h5A;
        mem_wr_ready <= hold ? 1'b0 : 1'($urandom_range(1));
        if (ce && mem_wr_valid && mem_wr_ready)
            cmp({mem_wr_addr, mem_wr_data}, wq.size() ? wq.pop_front() : {30{1'bx}}, "write");
        if (cmd_valid)
            cmp({cmd_code, cmd_param}, cq.size() ? cq.pop_front() : {30{1'bx}}, "command");
        if (rx_stb)
            cmp(rx_byte, rq.size() ? rq.pop_front() : {30{1'bx}}, "read");
        if (wr_commit)
            cmp(30'h1, mq.size() ? mq.pop_front() : {30{1'bx}}, "commit");
        if (probe && cur_w != 2'h0)
            cmp(oe, !rx_phase ? 4'h0 : (cur_w == 2'h2) ? 4'hF : 4'h3, "lane enable");
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic xfer(input logic [1:0] w, input logic [1:0] t, input logic [21:0] a, input int n,
        input int keep, input logic [7:0] d0);
        logic [7:0] d;
        h.start();
        if (t == HDR_WRITE && n > 0)
            mq.push_back(30'h1);
        h.xbyte(w, {t, a[21:16]}, 1'b1, 1'b0);
        h.xbyte(w, a[15:8], 1'b1, 1'b0);
        h.xbyte(w, a[7:0], 1'b1, 1'b0);
        if (t == HDR_READ)
            h.xbyte(w, 8'h00, 1'b0, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            d = (i == 0) ? d0 : 8'($urandom);
            if (t == HDR_READ)
                rq.push_back((a[7:0] + 8'(i)) ^ 8'h5A);
            else if (i < keep)
                wq.push_back({a + 22'(i), d});
            h.xbyte(w, d, t != HDR_READ, t == HDR_READ);
        end
        h.stop();
    endtask
    task automatic setw(input logic [1:0] nw);
        xfer(cur_w, HDR_WRITE, WIDTH_REG_ADDR, 1, 0, {6'h00, nw});
        if (nw != 2'h3)
            cur_w = nw;
        cmp(lane_width, cur_w, "width");
    endtask
    task automatic drain();
        for (int k = 0; k < 400 && wq.size() > 0; k++)
            @(posedge core_clk);
    endtask
    initial
    begin
        rst = 1'b1;
        hold = 1'b0;
        ce = 1'b1;
        cur_w = 2'h0;
        mem_rd_valid = 1'b0;
        mem_rd_data = 8'h00;
        mem_wr_ready = 1'b0;
        void'($urandom(32'hD302));
        base = {2'h0, 20'($urandom)};
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        cmp(lane_width, 2'h0, "reset width");
        cmp(oe, 4'h0, "reset enable");
        xfer(2'h0, HDR_WRITE, base, 3, 3, 8'($urandom));
        xfer(2'h0, HDR_READ, base, 2, 0, 8'h00);
        cq.push_back({6'h15, 8'hA7});
        xfer(2'h0, HDR_CMD, {6'h15, 8'hA7, 8'h00}, 0, 0, 8'h00);
        xfer(2'h0, HDR_BAD, base, 2, 0, 8'($urandom));
        for (int m = 1; m < 3; m++)
        begin
            setw(2'(m));
            xfer(cur_w, HDR_READ, base + 22'(m), 3, 0, 8'h00);
            cmp(oe, 4'h0, "enable after select");
            xfer(cur_w, HDR_WRITE, base, 2, 2, 8'($urandom));
            xfer(cur_w, HDR_CMD, {6'h15, 8'hA7, 8'h00}, 0, 0, 8'h00);
        end
        setw(2'h3);
        setw(2'h0);
        setw(2'h1);
        cq.push_back({CMD_SYS_RESET, 8'h00});
        xfer(cur_w, HDR_CMD, {CMD_SYS_RESET, 16'h0000}, 0, 0, 8'h00);
        cur_w = 2'h0;
        cmp(lane_width, cur_w, "width after system reset");
        drain();
        hold = 1'b1;
        xfer(2'h0, HDR_WRITE, base, DEPTH + 1, DEPTH, 8'($urandom));
        cmp(wr_buf_ready, 1'b0, "buffer ready when full");
        cmp(wr_overflow, 1'b1, "overflow");
        ce <= 1'b0;
        hold = 1'b0;
        repeat (20) @(posedge core_clk);
        cmp(wr_buf_ready, 1'b0, "buffer moved while disabled");
        ce <= 1'b1;
        drain();
        cmp(wr_buf_ready, 1'b1, "buffer ready when empty");
        cmp(wq.size() + rq.size() + cq.size() + mq.size(), 30'h0, "outstanding notes");
        wrap_up();
    end
endmodule
